//--- hw/hpsel_pkg.sv
// Purpose: Shared constants and types for the hot-plug port select logic
// Assumes: REF_CLK at 250 MHz (4 ns period)
// Notes: Times are kept in their printed unit; cycle counts derive from them
package hpsel_pkg;
   localparam int CLK_PERIOD_NS = 4;

   // Priority-change pause window, least bound rounded up to whole cycles
   localparam int PAUSE_MIN_MS = 2;
   localparam int PAUSE_MAX_US = 4700;
   localparam int PAUSE_CYC_DEF = (PAUSE_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Unplug switch window, used for detection and forced-low length
   localparam int SWITCH_MIN_MS = 170;
   localparam int SWITCH_MAX_MS = 400;
   localparam int SWITCH_CYC_DEF = (SWITCH_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Shortest low pulse that must be repeated
   localparam int MIN_PULSE_NS = 100;
   localparam int MIN_PULSE_CYC = MIN_PULSE_NS / CLK_PERIOD_NS;

   // Repeat and wake delays share one path; least bound sets the pipe depth
   localparam int REPEAT_MIN_NS = 30;
   localparam int REPEAT_MAX_NS = 110;
   localparam int REPEAT_MIN_CYC = (REPEAT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REPEAT_MAX_CYC = REPEAT_MAX_NS / CLK_PERIOD_NS;
   localparam int SYNC_LAT_CYC = 4;
   localparam int HP_PIPE_DEPTH = REPEAT_MIN_CYC - SYNC_LAT_CYC - 1;

   // Reset values
   localparam logic SEL_RST = 1'b0;
   localparam logic OUT_RST = 1'b0;

   typedef enum logic [1:0] {
      ST_LOWPWR,
      ST_FOLLOW,
      ST_PAUSE,
      ST_FORCE
   } hpsel_state_t;
endpackage

//--- hw/hpsel_sync.sv
// Purpose: Three-flop pin synchroniser with agreement filter
// Assumes: din is asynchronous to clk
// Notes: Output moves only when the second and third stages agree
`timescale 1ns/1ps
module hpsel_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic en,
   input wire logic din,
   output logic dout
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic out_reg;

   // First stage feeds only the second, so metastability never reaches logic
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         out_reg <= 1'b0;
      end else if (en) begin
         s1_reg <= din;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            out_reg <= s3_reg;
         end
      end
   end

   assign dout = out_reg;
endmodule

//--- hw/hpsel_timer.sv
// Purpose: Restartable cycle counter for pause and switch timing
// Assumes: LIMIT of at least 2
// Notes: done is high in the last counted cycle; start wins over stop
`timescale 1ns/1ps
module hpsel_timer #(
   parameter int LIMIT = 16,
   parameter int W = $clog2(LIMIT + 1)
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic en,
   input wire logic start,
   input wire logic stop,
   output logic run,
   output logic done,
   output logic [W-1:0] cnt
);
   logic run_reg;
   logic [W-1:0] cnt_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         run_reg <= 1'b0;
         cnt_reg <= '0;
      end else if (en) begin
         if (start) begin
            run_reg <= 1'b1;
            cnt_reg <= '0;
         end else if (stop || done) begin
            run_reg <= 1'b0;
         end else if (run_reg) begin
            cnt_reg <= cnt_reg + W'(1);
         end
      end
   end

   assign run = run_reg;
   assign done = run_reg && (cnt_reg == W'(LIMIT - 1));
   assign cnt = cnt_reg;
endmodule

//--- hw/hpsel_top.sv
// Purpose: Port select and hot-plug repeat logic for a one-to-two link switch
// Assumes: All pin inputs asynchronous; one free-running REF_CLK
// Notes: Decisions act on delayed hot-plug levels so output latency is fixed
`timescale 1ns/1ps
module hpsel_top
   import hpsel_pkg::*;
#(
   parameter int PAUSE_CYC = PAUSE_CYC_DEF,
   parameter int SWITCH_CYC = SWITCH_CYC_DEF,
   parameter bit PRIO_HIGH_PREFERS_A = 1'b1
) (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic CLK_EN,
   input wire logic SINK_A_HOTPLUG_IN,
   input wire logic SINK_B_HOTPLUG_IN,
   input wire logic PRIORITY_IN,
   input wire logic LOW_POWER_N_IN,
   output logic SOURCE_HOTPLUG_OUT,
   output logic SOURCE_HOTPLUG_OE_N,
   output logic PORT_SEL_VALID,
   output logic PORT_B_SELECT,
   output logic MAIN_LINK_OE_N,
   output logic AUX_OE_N
);
   localparam int PS_W = $clog2(PAUSE_CYC + 1);
   localparam int SW_W = $clog2(SWITCH_CYC + 1);

   logic a_s;
   logic b_s;
   logic prio_s;
   logic lpn_s;
   logic [HP_PIPE_DEPTH-1:0] a_pipe_reg;
   logic [HP_PIPE_DEPTH-1:0] b_pipe_reg;
   logic a_d;
   logic b_d;
   hpsel_state_t state_reg;
   hpsel_state_t state_next;
   logic sel_reg;
   logic sel_next;
   logic valid_reg;
   logic valid_next;
   logic tgt_reg;
   logic tgt_next;
   logic prio_seen_reg;
   logic pref_b;
   logic prio_chg;
   logic sel_lvl;
   logic oth_lvl;
   logic tgt_lvl;
   logic next_lvl;
   logic sw_start;
   logic sw_stop;
   logic sw_run;
   logic sw_done;
   logic [SW_W-1:0] sw_cnt;
   logic ps_start;
   logic ps_stop;
   logic ps_run;
   logic ps_done;
   logic [PS_W-1:0] ps_cnt;
   logic src_out_reg;
   logic src_oe_n_reg;
   logic link_oe_n_reg;

   // Pulses shorter than the filter window may vanish here
   hpsel_sync u_sync_a (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .en(CLK_EN),
      .din(SINK_A_HOTPLUG_IN),
      .dout(a_s)
   );
   hpsel_sync u_sync_b (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .en(CLK_EN),
      .din(SINK_B_HOTPLUG_IN),
      .dout(b_s)
   );
   hpsel_sync u_sync_prio (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .en(CLK_EN),
      .din(PRIORITY_IN),
      .dout(prio_s)
   );
   hpsel_sync u_sync_lpn (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .en(CLK_EN),
      .din(LOW_POWER_N_IN),
      .dout(lpn_s)
   );

   // Pause timer, least documented bound
   hpsel_timer #(.LIMIT(PAUSE_CYC), .W(PS_W)) u_pause_tmr (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .en(CLK_EN),
      .start(ps_start),
      .stop(ps_stop),
      .run(ps_run),
      .done(ps_done),
      .cnt(ps_cnt)
   );

   // One switch timer serves both unplug detect and forced low
   hpsel_timer #(.LIMIT(SWITCH_CYC), .W(SW_W)) u_switch_tmr (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .en(CLK_EN),
      .start(sw_start),
      .stop(sw_stop),
      .run(sw_run),
      .done(sw_done),
      .cnt(sw_cnt)
   );

   // Fixed delay keeps repeat latency inside its window, any pulse width that passes the sync filter
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         a_pipe_reg <= '0;
         b_pipe_reg <= '0;
      end else if (CLK_EN) begin
         a_pipe_reg <= {a_pipe_reg[HP_PIPE_DEPTH-2:0], a_s};
         b_pipe_reg <= {b_pipe_reg[HP_PIPE_DEPTH-2:0], b_s};
      end
   end

   assign a_d = a_pipe_reg[HP_PIPE_DEPTH-1];
   assign b_d = b_pipe_reg[HP_PIPE_DEPTH-1];
   assign pref_b = PRIO_HIGH_PREFERS_A ? !prio_s : prio_s;
   assign prio_chg = (prio_s != prio_seen_reg);
   assign sel_lvl = sel_reg ? b_d : a_d;
   assign oth_lvl = sel_reg ? a_d : b_d;
   assign tgt_lvl = tgt_reg ? b_d : a_d;
   assign next_lvl = sel_next ? b_d : a_d;

   always_comb begin
      state_next = state_reg;
      sel_next = sel_reg;
      valid_next = valid_reg;
      tgt_next = tgt_reg;
      sw_start = 1'b0;
      sw_stop = 1'b0;
      ps_start = 1'b0;
      ps_stop = 1'b0;
      case (state_reg)
         ST_LOWPWR: begin
            if (a_d || b_d) begin
               valid_next = 1'b1;
               sel_next = (a_d && b_d) ? pref_b : b_d;
               state_next = ST_FOLLOW;
            end
         end
         ST_FOLLOW: begin
            // No branch acts on the other port alone; it is ignored while the selected port is high and the preferred one and priority is steady
            if (!sel_lvl) begin
               if (!sw_run) begin
                  sw_start = 1'b1;
               end else if (sw_done) begin
                  if (oth_lvl) begin
                     sel_next = !sel_reg;
                  end else begin
                     valid_next = 1'b0;
                     state_next = ST_LOWPWR;
                  end
               end
            end else if (sw_run) begin
               sw_stop = 1'b1;
            end else if (oth_lvl && prio_chg) begin
               ps_start = 1'b1;
               state_next = ST_PAUSE;
            end else if (oth_lvl && (sel_reg != pref_b)) begin
               tgt_next = pref_b;
               sw_start = 1'b1;
               state_next = ST_FORCE;
            end
         end
         ST_PAUSE: begin
            if (!sel_lvl || !oth_lvl) begin
               ps_stop = 1'b1;
               state_next = ST_FOLLOW;
            end else if (prio_chg) begin
               ps_start = 1'b1; // A bouncing pin keeps re-arming the pause
            end else if (ps_done) begin
               if (pref_b != sel_reg) begin
                  tgt_next = pref_b;
                  sw_start = 1'b1;
                  state_next = ST_FORCE;
               end else begin
                  state_next = ST_FOLLOW;
               end
            end
         end
         ST_FORCE: begin
            if (!a_d && !b_d) begin
               sw_stop = 1'b1;
               valid_next = 1'b0;
               state_next = ST_LOWPWR;
            end else if (!tgt_lvl) begin
               sw_start = 1'b1;
            end else if (sw_done) begin
               sel_next = tgt_reg;
               state_next = ST_FOLLOW;
            end
         end
         default: begin
            valid_next = 1'b0;
            state_next = ST_LOWPWR;
         end
      endcase
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_reg <= ST_LOWPWR;
         sel_reg <= SEL_RST;
         valid_reg <= 1'b0;
         tgt_reg <= SEL_RST;
      end else if (CLK_EN) begin
         state_reg <= state_next;
         sel_reg <= sel_next;
         valid_reg <= valid_next;
         tgt_reg <= tgt_next;
      end
   end

   // A change seen while the selected input is low stays pending
   // Held as well in the cycle that stops the unplug timer, or the change is lost
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         prio_seen_reg <= 1'b0;
      end else if (CLK_EN) begin
         if (!(state_reg == ST_FOLLOW && (!sel_lvl || sw_run))) begin
            prio_seen_reg <= prio_s;
         end
      end
   end

   // Outputs take next-state values so they line up with state_reg
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         src_out_reg <= OUT_RST;
         src_oe_n_reg <= 1'b1;
         link_oe_n_reg <= 1'b1;
      end else if (CLK_EN) begin
         if (state_next == ST_FOLLOW || state_next == ST_PAUSE) begin
            src_out_reg <= next_lvl;
         end else begin
            src_out_reg <= 1'b0;
         end
         src_oe_n_reg <= !valid_next;
         link_oe_n_reg <= !(valid_next && lpn_s);
      end
   end

   assign SOURCE_HOTPLUG_OUT = src_out_reg;
   assign SOURCE_HOTPLUG_OE_N = src_oe_n_reg;
   assign PORT_SEL_VALID = valid_reg;
   assign PORT_B_SELECT = sel_reg;
   assign MAIN_LINK_OE_N = link_oe_n_reg;
   assign AUX_OE_N = link_oe_n_reg;

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);

   lowpwr_off_a: assert property (state_reg == ST_LOWPWR |-> MAIN_LINK_OE_N && SOURCE_HOTPLUG_OE_N && !SOURCE_HOTPLUG_OUT)
      else $error("Low power state with outputs enabled");
   one_sink_a: assert property (CLK_EN && state_reg == ST_LOWPWR && a_d != b_d |=> PORT_SEL_VALID && (PORT_B_SELECT == $past(b_d)))
      else $error("Lone sink not selected");
   both_pref_a: assert property (CLK_EN && state_reg == ST_LOWPWR && a_d && b_d |=> PORT_B_SELECT == $past(pref_b))
      else $error("Priority port not chosen");
   lp_pin_off_a: assert property (CLK_EN && !lpn_s |=> MAIN_LINK_OE_N && AUX_OE_N)
      else $error("Link enabled with low-power pin low");
   wake_link_a: assert property (CLK_EN && lpn_s && state_reg == ST_LOWPWR && (a_d || b_d) |=> !MAIN_LINK_OE_N && !AUX_OE_N && !SOURCE_HOTPLUG_OE_N)
      else $error("Link not woken");
   follow_out_a: assert property (CLK_EN && state_reg == ST_FOLLOW && state_next == ST_FOLLOW && sel_next == sel_reg |=> SOURCE_HOTPLUG_OUT == $past(sel_lvl))
      else $error("Source hot-plug not following");
   unplug_lp_a: assert property (CLK_EN && state_reg == ST_FOLLOW && !sel_lvl && sw_done && !oth_lvl |=> state_reg == ST_LOWPWR && !PORT_SEL_VALID)
      else $error("Unplug did not reach low power");
   unplug_other_a: assert property (CLK_EN && state_reg == ST_FOLLOW && !sel_lvl && sw_done && oth_lvl |=> PORT_B_SELECT != $past(PORT_B_SELECT))
      else $error("Other port not taken");
   prio_hold_a: assert property (CLK_EN && state_reg == ST_FOLLOW && sel_lvl && !sw_run && sel_reg == pref_b && !prio_chg |=> $stable(PORT_B_SELECT) && state_reg == ST_FOLLOW)
      else $error("Selection moved with priority port held");
   force_low_a: assert property (state_reg == ST_FORCE |-> !SOURCE_HOTPLUG_OUT)
      else $error("Source hot-plug high during forced low");
   restart_a: assert property (CLK_EN && state_reg == ST_FORCE && (a_d || b_d) && !tgt_lvl |=> sw_cnt == '0 && sw_run)
      else $error("Switch timer not restarted");
   force_done_a: assert property (CLK_EN && state_reg == ST_FORCE && (a_d || b_d) && tgt_lvl && sw_done |=> state_reg == ST_FOLLOW && PORT_B_SELECT == $past(tgt_reg))
      else $error("Priority port not taken after switch time");
   no_low_sel_a: assert property (CLK_EN && $past(state_reg) == ST_LOWPWR && state_reg == ST_FOLLOW |-> (PORT_B_SELECT ? $past(b_d) : $past(a_d)))
      else $error("Low port selected");
   pause_entry_a: assert property (CLK_EN && state_reg == ST_FOLLOW && sel_lvl && oth_lvl && !sw_run && prio_chg |=> state_reg == ST_PAUSE && ps_cnt == '0)
      else $error("Priority change not paused");
   pause_force_a: assert property (CLK_EN && state_reg == ST_PAUSE && sel_lvl && oth_lvl && !prio_chg && ps_done && pref_b != sel_reg |=> state_reg == ST_FORCE [*2])
      else $error("Pause did not lead to forced low");
   lone_timer_a: assert property (
      CLK_EN && state_reg == ST_FOLLOW && !sel_lvl && !sw_run |=> sw_run && sw_cnt == '0)
      else $error("Unplug timer not started");
   lp_follow_a: assert property (
      CLK_EN && !lpn_s && state_reg == ST_LOWPWR && (a_d || b_d) |=> PORT_SEL_VALID && !SOURCE_HOTPLUG_OE_N && MAIN_LINK_OE_N)
      else $error("Low-power select not following");
   force_unplug_a: assert property (
      CLK_EN && state_reg == ST_FORCE && !a_d && !b_d |=> state_reg == ST_LOWPWR && !PORT_SEL_VALID && SOURCE_HOTPLUG_OE_N)
      else $error("Both sinks low during forced low kept a port");
   pause_hold_a: assert property (
      CLK_EN && state_reg == ST_PAUSE && !ps_done |=> state_reg != ST_FORCE)
      else $error("Forced low before pause expired");
   other_quiet_a: assert property (
      CLK_EN && state_reg == ST_FOLLOW && sel_lvl && !sw_run && sel_reg == pref_b && !prio_chg |=> SOURCE_HOTPLUG_OUT == $past(sel_lvl))
      else $error("Other port disturbed the source hot-plug");

   force_cov: cover property (state_reg == ST_FORCE ##1 state_reg == ST_FOLLOW);
   wake_cov: cover property (state_reg == ST_LOWPWR ##1 state_reg == ST_FOLLOW);
   restart_cov: cover property (state_reg == ST_FORCE && !tgt_lvl && (a_d || b_d));
   pause_cov: cover property (state_reg == ST_PAUSE ##1 state_reg == ST_FORCE);
   unplug_cov: cover property (state_reg == ST_FOLLOW ##1 state_reg == ST_LOWPWR);
endmodule

//--- dv/hpsel_sink_model.sv
// Purpose: Two display sinks driving their hot-plug lines
// Assumes: Bench commands plug state and interrupt pulse requests
// Notes: A pulse drops the line low for pulse_len cycles, as a sink interrupt does
`timescale 1ns/1ps
module hpsel_sink_model (
   input wire logic clk,
   input wire logic plug_a,
   input wire logic plug_b,
   input wire logic pulse_a,
   input wire logic pulse_b,
   input wire logic [7:0] pulse_len,
   output logic hp_a,
   output logic hp_b
);
   logic [7:0] cnt_a_reg = 8'h00;
   logic [7:0] cnt_b_reg = 8'h00;

   always_ff @(posedge clk) begin
      if (pulse_a) begin
         cnt_a_reg <= pulse_len;
      end else if (cnt_a_reg != 8'h00) begin
         cnt_a_reg <= cnt_a_reg - 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (pulse_b) begin
         cnt_b_reg <= pulse_len;
      end else if (cnt_b_reg != 8'h00) begin
         cnt_b_reg <= cnt_b_reg - 8'h01;
      end
   end

   // Unplugged sink lines sit low, as with a pull-down
   assign hp_a = plug_a & (cnt_a_reg == 8'h00);
   assign hp_b = plug_b & (cnt_b_reg == 8'h00);
endmodule

//--- dv/hpsel_top_tb_top.sv
// Purpose: Self-checking bench for the hot-plug port select logic
// Assumes: Short pause and switch counts so the run stays brief
// Notes: Outputs are judged some cycles after each pin change, past the repeat delay, save the per-cycle B flap checks and one check 6 cycles into a wake
`timescale 1ns/1ps
module hpsel_top_tb_top;
   import hpsel_pkg::*;
   localparam int P_CYC = 20;
   localparam int S_CYC = 50;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic plug_a = 1'b0;
   logic plug_b = 1'b0;
   logic pulse_a = 1'b0;
   logic pulse_b = 1'b0;
   logic [7:0] pulse_len = 8'h00;
   logic prio = 1'b1;
   logic lp_n = 1'b0;
   logic clk_en = 1'b1;
   logic hp_a, hp_b, src_hp, src_oe_n, sel_valid, port_b, ml_oe_n, aux_oe_n;
   int fail_count = 0;
   int tests_run = 0;
   int seed = 32'h105c;
   int t0, w, bad;

   initial begin
      forever #2 ref_clk = ~ref_clk;
   end

   hpsel_sink_model i_sinks (.clk(ref_clk), .plug_a(plug_a), .plug_b(plug_b),
      .pulse_a(pulse_a), .pulse_b(pulse_b), .pulse_len(pulse_len), .hp_a(hp_a), .hp_b(hp_b));

   hpsel_top #(.PAUSE_CYC(P_CYC), .SWITCH_CYC(S_CYC), .PRIO_HIGH_PREFERS_A(1'b1)) i_dut (
      .REF_CLK(ref_clk), .RST_N(rst_n), .CLK_EN(clk_en), .SINK_A_HOTPLUG_IN(hp_a),
      .SINK_B_HOTPLUG_IN(hp_b), .PRIORITY_IN(prio), .LOW_POWER_N_IN(lp_n),
      .SOURCE_HOTPLUG_OUT(src_hp), .SOURCE_HOTPLUG_OE_N(src_oe_n), .PORT_SEL_VALID(sel_valid),
      .PORT_B_SELECT(port_b), .MAIN_LINK_OE_N(ml_oe_n), .AUX_OE_N(aux_oe_n));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // Expected port: a lone sink wins, otherwise priority high prefers A
   function automatic logic exp_b_sel(input logic a, input logic b, input logic pr);
      return (a && b) ? !pr : b;
   endfunction

   // Port B is meaningful only while a port is selected
   task automatic chk_st(input logic v, input logic pb, input logic o, input logic link);
      chk("port_sel_valid", 32'(v), 32'(sel_valid));
      if (v) chk("port_b_select", 32'(pb), 32'(port_b));
      chk("source_hotplug_out", 32'(o), 32'(src_hp));
      chk("source_hotplug_oe_n", 32'(!v), 32'(src_oe_n));
      chk("main_link_oe_n", 32'(!link), 32'(ml_oe_n));
      chk("aux_oe_n", 32'(!link), 32'(aux_oe_n));
   endtask

   task automatic pulse(input logic on_b, input int n);
      pulse_len = 8'(n);
      if (on_b) pulse_b = 1'b1;
      else pulse_a = 1'b1;
      cyc(1);
      pulse_a = 1'b0;
      pulse_b = 1'b0;
   endtask

   // Cycles until the source line falls, then how long it stays low
   task automatic measure_low(output int tw, output int wl);
      tw = 0;
      wl = 0;
      while (src_hp !== 1'b0 && tw < 200) begin
         @(negedge ref_clk);
         tw++;
      end
      while (src_hp === 1'b0 && wl < 400) begin
         @(negedge ref_clk);
         wl++;
      end
      cyc(1);
   endtask

   task automatic test_done();
      $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      #100000;
      fail_count++;
      test_done();
   end

   initial begin
      cyc(2);
      chk_st(1'b0, 1'b0, 1'b0, 1'b0);
      rst_n = 1'b1;
      cyc(2);
      chk_st(1'b0, 1'b0, 1'b0, 1'b0);
      plug_a = 1'b1;
      cyc(12);
      chk_st(1'b1, 1'b0, 1'b1, 1'b0);
      lp_n = 1'b1;
      cyc(12);
      chk_st(1'b1, exp_b_sel(plug_a, plug_b, prio), 1'b1, 1'b1);
      // Priority pin moves with a lone sink high
      for (int i = 0; i < 2; i++) begin
         prio = ~prio;
         cyc(P_CYC + S_CYC + 20);
         chk_st(1'b1, 1'b0, 1'b1, 1'b1);
      end
      // Random interrupt pulses on the selected sink, 25 to 40 cycles, below the switch time
      repeat (4) begin
         w = 25 + ($random(seed) & 15);
         pulse(1'b0, w);
         bad = w;
         measure_low(t0, w);
         chk("repeat_delay_ok", 32'h1, 32'(t0 >= 7 && t0 <= 9));
         chk("repeat_width", 32'(bad), 32'(w));
         cyc(5);
      end
      // Non-priority sink flaps while the priority port is selected
      bad = 0;
      repeat (60) begin
         plug_b = 1'($random(seed));
         cyc(1);
         if (src_hp !== 1'b1 || port_b !== 1'b0) bad++;
      end
      chk("other_port_ignored", 32'h0, 32'(bad));
      plug_b = 1'b1;
      cyc(12);
      chk_st(1'b1, exp_b_sel(plug_a, plug_b, prio), 1'b1, 1'b1);
      prio = 1'b0;
      cyc(10);
      chk_st(1'b1, 1'b0, 1'b1, 1'b1);
      measure_low(t0, w);
      chk("pause_ok", 32'h1, 32'(t0 >= P_CYC - 10 && t0 <= P_CYC + 4));
      chk("force_width_ok", 32'h1, 32'(w >= S_CYC && w <= S_CYC + 4));
      chk_st(1'b1, exp_b_sel(plug_a, plug_b, prio), 1'b1, 1'b1);
      // Short glitch on the priority pin is ignored
      prio = 1'b1;
      cyc(3);
      prio = 1'b0;
      cyc(P_CYC + S_CYC + 20);
      chk_st(1'b1, 1'b1, 1'b1, 1'b1);
      plug_b = 1'b0;
      cyc(20);
      chk_st(1'b1, 1'b1, 1'b0, 1'b1);
      cyc(S_CYC + 10);
      chk_st(1'b1, 1'b0, 1'b1, 1'b1);
      // Priority sink returns and blips during the forced low
      plug_b = 1'b1;
      cyc(20);
      chk_st(1'b1, 1'b0, 1'b0, 1'b1);
      pulse(1'b1, 5);
      cyc(S_CYC);
      chk_st(1'b1, 1'b0, 1'b0, 1'b1);
      cyc(30);
      chk_st(1'b1, 1'b1, 1'b1, 1'b1);
      plug_a = 1'b0;
      cyc(12);
      plug_b = 1'b0;
      cyc(20);
      chk_st(1'b1, 1'b1, 1'b0, 1'b1);
      cyc(S_CYC + 10);
      chk_st(1'b0, 1'b0, 1'b0, 1'b0);
      plug_b = 1'b1;
      cyc(6);
      chk_st(1'b0, 1'b0, 1'b0, 1'b0);
      cyc(6);
      chk_st(1'b1, 1'b1, 1'b1, 1'b1);
      lp_n = 1'b0;
      cyc(10);
      chk_st(1'b1, 1'b1, 1'b1, 1'b0);
      // Clock enable low freezes syncs, timers and outputs
      clk_en = 1'b0;
      plug_b = 1'b0;
      cyc(20);
      chk_st(1'b1, 1'b1, 1'b1, 1'b0);
      clk_en = 1'b1;
      cyc(12);
      chk_st(1'b1, 1'b1, 1'b0, 1'b0);
      test_done();
   end
endmodule
